// *** hdl/snlf_framer.sv ***
// signaling link framer: typed header, fragmentation, flows and resets
`timescale 1ns/100ps
`default_nettype none
// Operation
// - prefix every message with 8-bit type
// - type octet names the owning protocol
// - type codes 0x00..0x16, transports 0x17..0x1e
// - two flows: 0 best effort, 1 reliable
// - reliable flow keeps transmit and receive space bits
// - receive bit follows peer, mismatch means reset
// - best effort space 0 means no sequence
// - link packet is header plus contiguous octets
// - payload never exceeds current maximum size, a limit of 0 acts as 1
// - one payload holds one typed packet only
// - oversize typed packets split into fragments
// - five control messages for reset and status
// - sequence arithmetic unsigned modulo the space
// - half space ahead greater, behind smaller
// - link opened initializes both flows, both ends; not vr on a taken reliable octet, nor reassembly on best effort rx_hdr_i
// - link opened clears both space bits
// - each later reset toggles the space bit
// - request link open, accept opened indication
// - deliver received messages by type code
// - transmitter init zeroes send counter
// - sequence field equals send counter, advances
module snlf_framer #(
   parameter int LEN_W = snlf_pkg::LEN_W
) (
   input wire logic ref_clk_i, // 100 MHz clock
   input wire logic reset_i, // sync reset, active high
   input wire logic [3:0] avs_address_i, // byte address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic [31:0] avs_writedata_i, // write data
   input wire logic [3:0] avs_byteenable_i, // byte lanes
   output logic [31:0] avs_readdata_o, // read data
   output logic avs_waitrequest_o, // stall
   input wire logic msg_valid_i, // message octet valid
   output logic msg_ready_o, // message octet taken
   input wire logic [7:0] msg_type_i, // owner type code
   input wire logic msg_flow_i, // delivery flow
   input wire logic [LEN_W-1:0] msg_len_i, // message octets
   input wire logic [7:0] msg_data_i, // message octet
   input wire logic [LEN_W-1:0] max_payload_i, // current payload limit
   output logic open_link_cmd_o, // open request pulse
   input wire logic link_opened_ind_i, // opened pulse
   output logic lnk_valid_o, // link octet valid
   input wire logic lnk_ready_i, // link octet taken
   output logic [7:0] lnk_data_o, // link octet
   output logic lnk_sop_o, // first octet of payload
   output logic lnk_eop_o, // last octet of payload
   output snlf_pkg::snlf_hdr_t lnk_hdr_o, // payload header
   input wire logic rx_valid_i, // received octet valid
   input wire logic [7:0] rx_data_i, // received octet
   input wire logic rx_sop_i, // payload start
   input wire logic rx_eop_i, // payload end
   input wire snlf_pkg::snlf_hdr_t rx_hdr_i, // payload header
   output logic up_valid_o, // delivered octet valid
   output logic [7:0] up_type_o, // owner type code
   output logic [7:0] up_data_o, // delivered octet
   output logic up_first_o, // first message octet
   output logic up_last_o, // last message octet
   output logic ctl_valid_o, // control message out valid
   input wire logic ctl_ready_i, // control message taken
   output snlf_pkg::snlf_ctl_t ctl_kind_o, // control kind
   output logic ctl_space_o, // space bit carried
   input wire snlf_pkg::snlf_ctl_msg_t ctl_in_i // control message in
);
   localparam int SW = snlf_pkg::SEQ_W;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   // modulo add, wraps in the sequence space
   function automatic logic [SW-1:0] seq_add(input logic [SW-1:0] a, input logic [LEN_W:0] n);
      return a + SW'(n);
   endfunction : seq_add

   logic link_open, cmd_sent, q_tx, q_rx, tx_wait, rx_rst;
   logic [SW-1:0] vs_be, vs_rd, vr;
   snlf_pkg::snlf_tx_st_t st;
   logic [7:0] ty_q;
   logic fl_q;
   logic [LEN_W:0] rem;
   logic [LEN_W-1:0] frag_left;
   logic [snlf_pkg::NUM_CK-1:0] pend, pend_set, pend_clr;
   logic sw_txrst, sw_rxrst, sw_rep, ack;

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, then the answer
   logic req, wr_go;
   always_comb begin
      req = avs_read_i | avs_write_i;
      avs_waitrequest_o = req & ~ack;
      wr_go = avs_write_i & ack & avs_byteenable_i[0];
   end

   // ack alternates so each request sees exactly one stall cycle
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) ack <= 1'b0;
      else ack <= req & ~ack;
   end

   // read data loads in the stall cycle and stands at the answer edge
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i & ~ack) begin
         case (avs_address_i)
            snlf_pkg::REG_STAT: avs_readdata_o <= 32'({st, rx_rst, tx_wait, q_rx, q_tx,
               link_open});
            snlf_pkg::REG_VS: avs_readdata_o <= (32'(vs_rd) << snlf_pkg::VS_RD_POS) |
               32'(vs_be);
            snlf_pkg::REG_VR: avs_readdata_o <= 32'(vr);
            default: avs_readdata_o <= 32'h0; // control reads zero, holes too
         endcase
      end
   end

   // control bits are write-one pulses
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sw_txrst <= 1'b0;
         sw_rxrst <= 1'b0;
         sw_rep <= 1'b0;
      end else begin
         sw_txrst <= wr_go & (avs_address_i == snlf_pkg::REG_CTRL) &
            avs_writedata_i[snlf_pkg::CTRL_TXRST];
         sw_rxrst <= wr_go & (avs_address_i == snlf_pkg::REG_CTRL) &
            avs_writedata_i[snlf_pkg::CTRL_RXRST];
         sw_rep <= wr_go & (avs_address_i == snlf_pkg::REG_CTRL) &
            avs_writedata_i[snlf_pkg::CTRL_REPORT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset and control message decode
   logic rx_req_in, rx_req_flip, tx_rst_go, tx_done, notice_in, notice_flip;
   logic tx_init_rd, rx_init;
   logic sop_rd, rx_mis, rx_lt, flip_data, rx_ign, rx_dup, rx_leave;
   always_comb begin
      rx_req_in = ctl_in_i.valid & (ctl_in_i.kind == snlf_pkg::CK_RX_REQ) & ~tx_wait;
      rx_req_flip = rx_req_in & (ctl_in_i.space != q_tx);
      tx_rst_go = sw_txrst & ~tx_wait;
      // a report with a stale space bit is ignored
      tx_done = ctl_in_i.valid & ((ctl_in_i.kind == snlf_pkg::CK_TX_ACK) |
         ((ctl_in_i.kind == snlf_pkg::CK_REPORT) & (ctl_in_i.space == q_tx)));
      notice_in = ctl_in_i.valid & (ctl_in_i.kind == snlf_pkg::CK_TX_NOTICE);
      notice_flip = notice_in & (ctl_in_i.space != q_rx);
      tx_init_rd = link_opened_ind_i | tx_rst_go | rx_req_flip;
      sop_rd = rx_valid_i & rx_sop_i & (rx_hdr_i.flow == snlf_pkg::FLOW_RD);
      rx_mis = sop_rd & (rx_hdr_i.space != q_rx);
      flip_data = rx_mis & ~rx_rst;
      rx_ign = rx_mis & rx_rst;
      rx_dup = sop_rd & ~rx_mis & rx_lt;
      rx_leave = rx_rst & ((ctl_in_i.valid & (ctl_in_i.kind == snlf_pkg::CK_RX_ACK)) |
         (sop_rd & ~rx_mis));
      rx_init = link_opened_ind_i | sw_rxrst | notice_flip | flip_data;
   end

   // open link once per pending message, opened indication marks it up
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         link_open <= 1'b0;
         cmd_sent <= 1'b0;
         open_link_cmd_o <= 1'b0;
      end else begin
         open_link_cmd_o <= msg_valid_i & ~link_open & ~cmd_sent;
         if (link_opened_ind_i) begin
            link_open <= 1'b1;
            cmd_sent <= 1'b0;
         end else if (msg_valid_i & ~link_open) begin
            cmd_sent <= 1'b1;
         end
      end
   end

   // transmit space bit: cleared on open, toggled on each later reset
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q_tx <= 1'b0;
         tx_wait <= 1'b0;
      end else if (link_opened_ind_i) begin
         q_tx <= 1'b0;
         tx_wait <= 1'b0;
      end else begin
         if (tx_rst_go | rx_req_flip) q_tx <= ~q_tx;
         // no new reset until the peer sends a tx ack, or a report with the new space bit
         if (tx_rst_go) tx_wait <= 1'b1;
         else if (tx_done) tx_wait <= 1'b0;
      end
   end

   // receive space bit tracks the peer and its own resets
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q_rx <= 1'b0;
         rx_rst <= 1'b0;
      end else if (link_opened_ind_i) begin
         q_rx <= 1'b0;
         rx_rst <= 1'b0;
      end else begin
         if (sw_rxrst | notice_flip | flip_data) q_rx <= ~q_rx;
         if (sw_rxrst) rx_rst <= 1'b1;
         else if (rx_leave) rx_rst <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outgoing control messages, lowest kind first
   always_comb begin
      pend_set = '0;
      pend_set[snlf_pkg::CK_RX_REQ] = sw_rxrst;
      pend_set[snlf_pkg::CK_RX_ACK] = rx_req_in;
      pend_set[snlf_pkg::CK_TX_NOTICE] = tx_rst_go;
      pend_set[snlf_pkg::CK_TX_ACK] = notice_in;
      pend_set[snlf_pkg::CK_REPORT] = sw_rep;
      ctl_valid_o = |pend;
      ctl_kind_o = snlf_pkg::CK_RX_REQ;
      for (int i = snlf_pkg::NUM_CK - 1; i >= 0; i--) begin
         if (pend[i]) ctl_kind_o = snlf_pkg::snlf_ctl_t'(i);
      end
      case (ctl_kind_o)
         snlf_pkg::CK_RX_ACK, snlf_pkg::CK_TX_NOTICE: ctl_space_o = q_tx;
         default: ctl_space_o = q_rx;
      endcase
      pend_clr = '0;
      pend_clr[ctl_kind_o] = ctl_valid_o & ctl_ready_i;
   end

   // a new request of a kind wins over its clear
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) pend <= '0;
      else pend <= (pend & ~pend_clr) | pend_set;
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit framing terms
   logic can_load, load, new_pay, last_pay, whole, seq_on, first_pay;
   logic [LEN_W:0] maxp, pay_size, cnt;
   always_comb begin
      maxp = (max_payload_i == '0) ? (LEN_W+1)'(1) : {1'b0, max_payload_i};
      can_load = ~lnk_valid_o | lnk_ready_i;
      msg_ready_o = (st == snlf_pkg::ST_BODY) & can_load;
      load = ((st == snlf_pkg::ST_TYPE) & can_load) | (msg_valid_i & msg_ready_o);
      new_pay = load & (frag_left == '0);
      last_pay = rem <= maxp;
      pay_size = last_pay ? rem : maxp;
      first_pay = st == snlf_pkg::ST_TYPE;
      whole = first_pay & last_pay;
      seq_on = (fl_q == snlf_pkg::FLOW_RD) | ~whole;
      cnt = new_pay ? pay_size : {1'b0, frag_left};
   end

   // framer: type octet, then the body, one typed packet at a time
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         st <= snlf_pkg::ST_IDLE;
         ty_q <= 8'h00;
         fl_q <= snlf_pkg::FLOW_BE;
         rem <= '0;
      end else begin
         case (st)
            snlf_pkg::ST_IDLE: begin
               if (msg_valid_i & link_open) begin
                  ty_q <= msg_type_i;
                  fl_q <= msg_flow_i;
                  rem <= {1'b0, msg_len_i} + (LEN_W+1)'(1);
                  st <= snlf_pkg::ST_TYPE;
               end
            end
            snlf_pkg::ST_TYPE: begin
               if (load) begin
                  rem <= rem - (LEN_W+1)'(1);
                  st <= (rem == (LEN_W+1)'(1)) ? snlf_pkg::ST_IDLE : snlf_pkg::ST_BODY;
               end
            end
            snlf_pkg::ST_BODY: begin
               if (load) begin
                  rem <= rem - (LEN_W+1)'(1);
                  if (rem == (LEN_W+1)'(1)) st <= snlf_pkg::ST_IDLE;
               end
            end
            default: st <= snlf_pkg::ST_IDLE;
         endcase
      end
   end

   // output octet register: header rides with every octet of a payload
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         lnk_valid_o <= 1'b0;
         lnk_data_o <= 8'h00;
         lnk_sop_o <= 1'b0;
         lnk_eop_o <= 1'b0;
         lnk_hdr_o <= '0;
         frag_left <= '0;
      end else if (load) begin
         lnk_valid_o <= 1'b1;
         lnk_data_o <= first_pay ? ty_q : msg_data_i;
         lnk_sop_o <= new_pay;
         lnk_eop_o <= cnt == (LEN_W+1)'(1);
         frag_left <= LEN_W'(cnt - (LEN_W+1)'(1));
         if (new_pay) begin
            lnk_hdr_o.flow <= fl_q;
            lnk_hdr_o.space <= (fl_q == snlf_pkg::FLOW_RD) ? q_tx : ~whole;
            lnk_hdr_o.first <= first_pay;
            lnk_hdr_o.last <= last_pay;
            lnk_hdr_o.seq <= (fl_q == snlf_pkg::FLOW_RD) ? vs_rd : vs_be;
         end
      end else if (lnk_ready_i) begin
         lnk_valid_o <= 1'b0;
      end
   end

   // send counters: zeroed by init, advanced by payload size when sequenced
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         vs_be <= '0;
         vs_rd <= '0;
      end else begin
         if (link_opened_ind_i) vs_be <= '0;
         else if (new_pay & seq_on & (fl_q == snlf_pkg::FLOW_BE)) vs_be <= seq_add(vs_be,
            pay_size);
         if (tx_init_rd) vs_rd <= '0;
         else if (new_pay & (fl_q == snlf_pkg::FLOW_RD)) vs_rd <= seq_add(vs_rd, pay_size);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive: duplicate check, reassembly and dispatch by type
   snlf_seq_cmp #(.W(SW)) u_cmp (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .a_i(rx_hdr_i.seq),
      .x_i(vr),
      .gt_o(),
      .lt_o(rx_lt)
   );

   logic pay_ok, oct_ok, eff_first, eff_last, in_pkt, known, first_pend;
   always_comb begin
      // an unsequenced best effort payload is a whole typed packet
      eff_first = rx_hdr_i.first | ((rx_hdr_i.flow == snlf_pkg::FLOW_BE) & ~rx_hdr_i.space);
      eff_last = rx_hdr_i.last | ((rx_hdr_i.flow == snlf_pkg::FLOW_BE) & ~rx_hdr_i.space);
      oct_ok = rx_valid_i & (rx_sop_i ? ~(rx_ign | rx_dup) : pay_ok);
   end

   // expected receive number, zeroed on receiver init unless a reliable octet is taken that cycle
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         vr <= '0;
         pay_ok <= 1'b0;
      end else begin
         if (rx_valid_i & rx_sop_i) pay_ok <= ~(rx_ign | rx_dup);
         if (oct_ok & (rx_hdr_i.flow == snlf_pkg::FLOW_RD)) begin
            vr <= seq_add(rx_sop_i ? rx_hdr_i.seq : vr, (LEN_W+1)'(1));
         end else if (rx_init) begin
            vr <= '0;
         end
      end
   end

   // first octet of a first fragment is the type; later octets go up
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         in_pkt <= 1'b0;
         known <= 1'b0;
         first_pend <= 1'b0;
         up_valid_o <= 1'b0;
         up_type_o <= 8'h00;
         up_data_o <= 8'h00;
         up_first_o <= 1'b0;
         up_last_o <= 1'b0;
      end else begin
         up_valid_o <= 1'b0;
         if (oct_ok & rx_sop_i & eff_first) begin
            up_type_o <= rx_data_i;
            known <= rx_data_i <= snlf_pkg::TYPE_TPT7;
            in_pkt <= ~(rx_eop_i & eff_last);
            first_pend <= 1'b1;
         end else if (oct_ok & in_pkt) begin
            up_valid_o <= known; // unknown owners are dropped
            up_data_o <= rx_data_i;
            up_first_o <= first_pend;
            up_last_o <= rx_eop_i & eff_last;
            first_pend <= 1'b0;
            if (rx_eop_i & eff_last) in_pkt <= 1'b0;
         end else if (rx_init & (rx_hdr_i.flow == snlf_pkg::FLOW_RD)) begin
            in_pkt <= 1'b0; // reassembly emptied on receiver init while rx_hdr_i shows the reliable flow
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_type_slot;
      (st == snlf_pkg::ST_TYPE) && can_load;
   endsequence
   sequence s_type_out;
      ##1 lnk_valid_o && lnk_sop_o && lnk_hdr_o.first && (lnk_data_o == ty_q);
   endsequence
   property p_type_first;
      s_type_slot |-> s_type_out;
   endproperty
   a_type_first: assert property (p_type_first) else $error("type octet not first");

   property p_pay_max;
      new_pay |-> (pay_size <= maxp) && (pay_size != '0);
   endproperty
   a_pay_max: assert property (p_pay_max) else $error("payload over limit");

   property p_pkt_end;
      (load && rem == (LEN_W+1)'(1)) |=> lnk_eop_o && lnk_hdr_o.last;
   endproperty
   a_pkt_end: assert property (p_pkt_end) else $error("packet end not payload end");

   property p_open_clear;
      link_opened_ind_i |=> !q_tx && !q_rx && (vs_rd == '0) && (vs_be == '0);
   endproperty
   a_open_clear: assert property (p_open_clear) else $error("open did not clear");

   property p_tx_toggle;
      (tx_rst_go && !link_opened_ind_i) |=> (q_tx != $past(q_tx)) && tx_wait;
   endproperty
   a_tx_toggle: assert property (p_tx_toggle) else $error("tx space bit not toggled");

   property p_rx_follow;
      (notice_flip && !link_opened_ind_i && !sw_rxrst && !flip_data) |=>
         q_rx == $past(ctl_in_i.space);
   endproperty
   a_rx_follow: assert property (p_rx_follow) else $error("rx bit not following");

   property p_be_whole;
      (new_pay && whole && fl_q == snlf_pkg::FLOW_BE) |=> !lnk_hdr_o.space && $stable(vs_be);
   endproperty
   a_be_whole: assert property (p_be_whole) else $error("whole packet sequenced");

   property p_open_cmd;
      (msg_valid_i && !link_open && !cmd_sent) |=> open_link_cmd_o ##1 !open_link_cmd_o;
   endproperty
   a_open_cmd: assert property (p_open_cmd) else $error("open request missing");
endmodule : snlf_framer
`default_nettype wire

// *** hdl/snlf_pkg.sv ***
// package: constants, codes, states and carriers of the signaling link framer
package snlf_pkg;
   // octet sequence length, a synthesis-time constant
   localparam int SEQ_W = 12;
   // width of payload and message octet counts
   localparam int LEN_W = 12;
   // protocol-type codes of the one-octet typed header
   localparam logic [7:0] TYPE_PHY = 8'h00;
   localparam logic [7:0] TYPE_SMP = 8'h11;
   localparam logic [7:0] TYPE_PCP = 8'h16;
   localparam logic [7:0] TYPE_TPT0 = 8'h17;
   localparam logic [7:0] TYPE_TPT7 = 8'h1e;
   // delivery flow selector values
   localparam logic FLOW_BE = 1'b0;
   localparam logic FLOW_RD = 1'b1;
   // register byte offsets on the avalon slave
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_VS = 4'h8;
   localparam logic [3:0] REG_VR = 4'hc;
   // control register bit positions, write-one pulses
   localparam int CTRL_TXRST = 0;
   localparam int CTRL_RXRST = 1;
   localparam int CTRL_REPORT = 2;
   // status register bit positions
   localparam int STAT_OPEN = 0;
   localparam int STAT_QTX = 1;
   localparam int STAT_QRX = 2;
   localparam int STAT_TXWAIT = 3;
   localparam int STAT_RXRST = 4;
   localparam int STAT_ST = 5;
   // field position of the reliable send counter in REG_VS
   localparam int VS_RD_POS = 16;
   localparam int NUM_CK = 5;
   // control message kinds used for reset and status exchange
   typedef enum logic [2:0] {
      CK_RX_REQ = 3'h0,
      CK_RX_ACK = 3'h1,
      CK_TX_NOTICE = 3'h2,
      CK_TX_ACK = 3'h3,
      CK_REPORT = 3'h4
   } snlf_ctl_t;
   // transmit framer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_TYPE = 3'b010,
      ST_BODY = 3'b100
   } snlf_tx_st_t;
   // link packet header carried beside the payload octets
   typedef struct packed {
      logic flow;
      logic space;
      logic first;
      logic last;
      logic [SEQ_W-1:0] seq;
   } snlf_hdr_t;
   // one control message with its sequence-space bit
   typedef struct packed {
      logic valid;
      snlf_ctl_t kind;
      logic space;
   } snlf_ctl_msg_t;
endpackage : snlf_pkg

// *** hdl/snlf_seq_cmp.sv ***
// modulo sequence comparator for octet sequence numbers
`timescale 1ns/100ps
`default_nettype none
module snlf_seq_cmp #(
   parameter int W = snlf_pkg::SEQ_W
) (
   input wire logic ref_clk_i, // clock, only for checks
   input wire logic reset_i, // sync reset, only for checks
   input wire logic [W-1:0] a_i, // number under test
   input wire logic [W-1:0] x_i, // reference number
   output logic gt_o, // a is ahead of x
   output logic lt_o // a is behind x
);
   logic [W-1:0] diff;
   localparam logic [W-1:0] HALF = W'(1) << (W - 1);

   // unsigned difference wraps, so half the space splits ahead from behind
   always_comb begin
      diff = a_i - x_i;
      gt_o = (diff != '0) && (diff < HALF);
      lt_o = diff >= HALF;
   end

   property p_cmp_split;
      @(posedge ref_clk_i) disable iff (reset_i)
         (a_i == W'(x_i + HALF)) |-> (lt_o && !gt_o);
   endproperty
   a_cmp_split: assert property (p_cmp_split) else $error("half offset not smaller");
endmodule : snlf_seq_cmp
`default_nettype wire

// *** testbench/snlf_pcl_model.sv ***
// link-side partner model: takes link octets, can stall, logs them
`timescale 1ns/100ps
`default_nettype none
module snlf_pcl_model (
   input wire logic ref_clk_i, // clock
   input wire logic slow_i, // stall every other cycle
   input wire logic lnk_valid_i, // octet offered
   input wire logic [7:0] lnk_data_i, // octet
   input wire logic lnk_sop_i, // payload start
   input wire logic lnk_eop_i, // payload end
   input wire snlf_pkg::snlf_hdr_t lnk_hdr_i, // payload header
   output logic lnk_ready_o // octet taken
);
   logic [25:0] log_q[$];
   logic ph = 1'b0;
   // log every accepted octet; stalls force the framer to hold its octet
   always @(posedge ref_clk_i) begin
      ph <= ~ph;
      if (lnk_valid_i && lnk_ready_o) begin
         log_q.push_back({lnk_sop_i, lnk_eop_i, lnk_hdr_i, lnk_data_i});
      end
   end
   assign lnk_ready_o = ~slow_i | ph;
endmodule : snlf_pcl_model
`default_nettype wire

// *** testbench/test_signaling_network_link_framer.sv ***
// bench for the link framer: registers, transmit framing, receive dispatch
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module test_signaling_network_link_framer;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wt, mv = 1'b0, mr, mf = 1'b0, oc;
   logic opi = 1'b0, lv, lr, sop, eop, rv = 1'b0, rs = 1'b0, re = 1'b0, uv, uf, ul, slow = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, rdat, got;
   logic [7:0] mt = 8'h0, md = 8'h0, ld, rxd = 8'h0, ut, ud;
   logic [11:0] ml = 12'h0, mx = 12'h8;
   snlf_pkg::snlf_hdr_t lh, rh = snlf_pkg::snlf_hdr_t'(16'h3000);
   int fails = 0, tests_run = 0, opens = 0;
   logic [17:0] up_q[$];
   logic cv, cs;
   snlf_pkg::snlf_ctl_t ck;
   snlf_pkg::snlf_ctl_msg_t ci = '0;
   logic [3:0] cq[$];
   snlf_framer u_snlf_framer (.ref_clk_i(clk), .reset_i(rst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .msg_valid_i(mv), .msg_ready_o(mr),
      .msg_type_i(mt), .msg_flow_i(mf), .msg_len_i(ml), .msg_data_i(md), .max_payload_i(mx),
      .open_link_cmd_o(oc), .link_opened_ind_i(opi), .lnk_valid_o(lv), .lnk_ready_i(lr),
      .lnk_data_o(ld), .lnk_sop_o(sop), .lnk_eop_o(eop), .lnk_hdr_o(lh), .rx_valid_i(rv),
      .rx_data_i(rxd), .rx_sop_i(rs), .rx_eop_i(re), .rx_hdr_i(rh), .up_valid_o(uv),
      .up_type_o(ut), .up_data_o(ud), .up_first_o(uf), .up_last_o(ul), .ctl_valid_o(cv),
      .ctl_ready_i(1'b1), .ctl_kind_o(ck), .ctl_space_o(cs), .ctl_in_i(ci));
   snlf_pcl_model u_snlf_pcl_model (.ref_clk_i(clk), .slow_i(slow), .lnk_valid_i(lv),
      .lnk_data_i(ld), .lnk_sop_i(sop), .lnk_eop_i(eop), .lnk_hdr_i(lh), .lnk_ready_o(lr));
   always #5 clk = ~clk;
   // record open requests and delivered octets
   always @(posedge clk) begin
      if (oc) opens++;
      if (uv) up_q.push_back({ut, ud, uf, ul});
      if (cv) cq.push_back({ck, cs}); // ready is tied high, so each valid cycle is one message
   end
   ////////////////////////////////////////////////////////////
   task check(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask : check
   // avalon access: hold until waitrequest is low at the edge
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (wt);
      got = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task send(input logic [7:0] t, input logic f, input logic [11:0] l, m);
      @(posedge clk);
      mv <= 1'b1;
      mt <= t;
      mf <= f;
      ml <= l;
      mx <= m;
      md <= 8'h40;
      for (int i = 0; i < l; i++) begin
         do @(posedge clk); while (!mr);
         md <= 8'(8'h41 + i);
      end
      mv <= 1'b0;
   endtask : send
   // expected fragments worked out from length, limit and counter start
   task chk_pkt(input logic [7:0] t, input logic f, q, input int len, m, c0);
      int b;
      while (u_snlf_pcl_model.log_q.size() <= len) @(posedge clk);
      for (int i = 0; i <= len; i++) begin
         b = i - i % m;
         `CHK("link octet", {i % m == 0, i % m == m - 1 || i == len, f, q, b == 0,
            b + m > len, 12'(c0 + b), i == 0 ? t : 8'(8'h3f + i)},
            u_snlf_pcl_model.log_q.pop_front());
      end
   endtask : chk_pkt
   task rxb(input logic [7:0] t, d);
      @(posedge clk);
      rv <= 1'b1;
      rs <= 1'b1;
      rxd <= t;
      @(posedge clk);
      rs <= 1'b0;
      re <= 1'b1;
      rxd <= d;
      @(posedge clk);
      rv <= 1'b0;
      re <= 1'b0;
   endtask : rxb
   // one-cycle control message from the peer
   task ctl(input snlf_pkg::snlf_ctl_t k, input logic s);
      @(posedge clk);
      ci <= {1'b1, k, s};
      @(posedge clk);
      ci <= '0;
   endtask : ctl
   task test_done;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////
   // watchdog, far beyond the fewer than a hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, snlf_pkg::REG_STAT, 0);
      `CHK("status", 32'h20, got);
      fork
         send(8'h11, 1'b0, 12'd2, 12'd8);
         begin
            @(posedge oc);
            opi <= 1'b1;
            @(posedge clk);
            opi <= 1'b0;
         end
      join
      `CHK("open requests", 1, opens);
      chk_pkt(8'h11, 1'b0, 1'b0, 2, 8, 0);
      bus(1'b0, snlf_pkg::REG_VS, 0);
      `CHK("send counts", 0, got);
      $display("whole best effort packet done");
      slow <= 1'b1;
      send(8'h1e, 1'b1, 12'd5, 12'd4);
      chk_pkt(8'h1e, 1'b1, 1'b0, 5, 4, 0);
      bus(1'b0, snlf_pkg::REG_VS, 0);
      `CHK("send counts", 32'h0006_0000, got);
      $display("fragmented reliable packet done");
      bus(1'b1, snlf_pkg::REG_CTRL, 32'h1);
      bus(1'b0, snlf_pkg::REG_STAT, 0);
      `CHK("status", 32'h2b, got);
      bus(1'b0, snlf_pkg::REG_VS, 0);
      `CHK("send counts", 0, got);
      send(8'h17, 1'b1, 12'd1, 12'd0);
      chk_pkt(8'h17, 1'b1, 1'b1, 1, 1, 0);
      bus(1'b0, 4'h2, 0);
      `CHK("unmapped", 0, got);
      $display("transmitter reset done");
      rxb(8'h11, 8'ha5);
      rxb(8'h1f, 8'h5a);
      repeat (4) @(posedge clk);
      `CHK("delivered", 1, up_q.size());
      `CHK("delivered octet", {8'h11, 8'ha5, 2'b11}, up_q[0]);
      $display("receive dispatch done");
      // peer confirms the tx reset, then announces its own reset in space 1
      ctl(snlf_pkg::CK_TX_ACK, 1'b1);
      ctl(snlf_pkg::CK_TX_NOTICE, 1'b1);
      bus(1'b0, snlf_pkg::REG_STAT, 0);
      `CHK("status", 32'h27, got);
      `CHK("notice out", {snlf_pkg::CK_TX_NOTICE, 1'b1}, cq[0]);
      `CHK("notice ack out", {snlf_pkg::CK_TX_ACK, 1'b1}, cq[1]);
      $display("control exchange done");
      test_done();
   end
endmodule : test_signaling_network_link_framer
`default_nettype wire
